// ===== verilog/dmsp_port.sv
`timescale 1ns/1ps
`include "dmsp_defines.svh"

module dmsp_port #(
    parameter int RATE_W = 16
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    input wire logic i_protocol_select_pin,
    input wire logic i_serial_clock_line,
    input wire logic i_serial_data_line,
    output logic o_serial_data_line_oen,
    input wire logic i_select_line_n,
    input wire logic i_powerdown_detect_line,
    output logic o_powerdown_detect_line_oen,
    input wire logic i_rx_data,
    input wire logic [7:0] i_rssi_level,
    input wire logic [7:0] i_adc_value,
    output logic o_powerdown,
    output dmsp_pkg::dmsp_mode_type o_op_mode,
    output logic [15:0] o_config
);

    // registers that carry a single byte on the bus
    function automatic logic dmsp_is_byte_reg(input logic [3:0] sub);
        dmsp_is_byte_reg = (sub == `DMSP_SUB_LPF) || (sub == `DMSP_SUB_RSSI) ||
            (sub == `DMSP_SUB_CLK_DIV) || (sub == `DMSP_SUB_XTAL_CFG);
    endfunction

    // inclusive window test shared by the rate check
    function automatic logic dmsp_in_window(input logic [15:0] v,
            input logic [15:0] lo, input logic [15:0] hi);
        dmsp_in_window = (v >= lo) && (v <= hi);
    endfunction

    // ------------------------------------------------------------------
    // link domain, clocked by the bus clock and by the data and select lines
    // ------------------------------------------------------------------
    logic mode3w;
    logic scl;
    logic sda;
    logic start_tgl_q;
    logic stop_tgl_q;
    logic sel_tgl_q;
    logic start_seen_q;
    logic stop_seen_q;
    logic sel_seen_q;
    logic frame_start;
    logic stop_pend;
    dmsp_pkg::dmsp_link_type st_q;
    logic [2:0] cnt_q;
    logic [7:0] sh_q;
    logic [7:0] sh_n;
    logic [3:0] sub_q;
    logic rd_sel_q;
    logic rd_mode_q;
    logic dir_rd_q;
    logic [1:0] byte_q;
    logic [7:0] hi_q;
    logic tx_low_q;
    logic hold_q;
    logic wr_tgl_q;
    dmsp_pkg::dmsp_wr_type wr_q;
    logic [7:0] snap_q [2];
    logic [7:0] rd_byte;

    assign mode3w = i_protocol_select_pin;
    assign scl = i_serial_clock_line;
    assign sda = i_serial_data_line;
    assign sh_n = {sh_q[6:0], sda};
    assign rd_byte = snap_q[rd_sel_q];

    // start seen as data falling while clock high, two-wire only
    always_ff @(negedge i_serial_data_line or posedge i_rst) begin
        if (i_rst) begin
            start_tgl_q <= 1'b0;
        end else if (scl && !mode3w) begin
            start_tgl_q <= !start_tgl_q;
        end
    end

    // stop seen as data rising while clock high
    always_ff @(posedge i_serial_data_line or posedge i_rst) begin
        if (i_rst) begin
            stop_tgl_q <= 1'b0;
        end else if (scl && !mode3w) begin
            stop_tgl_q <= !stop_tgl_q;
        end
    end

    // a falling select opens a three-wire frame
    always_ff @(negedge i_select_line_n or posedge i_rst) begin
        if (i_rst) begin
            sel_tgl_q <= 1'b0;
        end else if (mode3w) begin
            sel_tgl_q <= !sel_tgl_q;
        end
    end

    // the clock stands still after a stop, so the engine notices the
    // stop or a new start only at the next clock edge; a stop without
    // a fresh start then parks it in idle
    assign frame_start = mode3w ? ((sel_tgl_q != sel_seen_q) && !i_select_line_n)
                                : (start_tgl_q != start_seen_q);
    assign stop_pend = !mode3w && (stop_tgl_q != stop_seen_q);

    always_ff @(posedge i_serial_clock_line or posedge i_rst) begin
        if (i_rst) begin
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
            sel_seen_q <= 1'b0;
        end else begin
            start_seen_q <= start_tgl_q;
            stop_seen_q <= stop_tgl_q;
            sel_seen_q <= sel_tgl_q;
        end
    end

    // serial engine: bits are sampled on the rising clock edge
    always_ff @(posedge i_serial_clock_line or posedge i_rst) begin
        if (i_rst) begin
            st_q <= dmsp_pkg::DMSP_IDLE;
            cnt_q <= `DMSP_FIRST_BIT;
            sh_q <= 8'h00;
            sub_q <= 4'h0;
            rd_sel_q <= 1'b0;
            rd_mode_q <= 1'b0;
            dir_rd_q <= 1'b0;
            byte_q <= 2'h0;
            hi_q <= 8'h00;
            tx_low_q <= 1'b0;
            hold_q <= 1'b0;
            wr_tgl_q <= 1'b0;
            wr_q <= '0;
        end else if (frame_start) begin
            // first bit of a frame is already on the line
            st_q <= mode3w ? dmsp_pkg::DMSP_SUB : dmsp_pkg::DMSP_ADDR;
            cnt_q <= 3'h1;
            sh_q <= sh_n;
            tx_low_q <= 1'b0;
            byte_q <= 2'h0;
            // a read subaddress is known from its msb; freezing the
            // snapshot this early gives the crossing time to settle
            hold_q <= mode3w ? sda : hold_q;
        end else if ((mode3w && i_select_line_n) || stop_pend) begin
            st_q <= dmsp_pkg::DMSP_IDLE;
            tx_low_q <= 1'b0;
        end else begin
            case (st_q)
                dmsp_pkg::DMSP_ADDR: begin
                    cnt_q <= cnt_q + 3'h1;
                    sh_q <= sh_n;
                    if (cnt_q == `DMSP_LAST_BIT) begin
                        if (sh_n[7:1] == `DMSP_DEV_ADDR) begin
                            st_q <= dmsp_pkg::DMSP_ADDR_ACK;
                            dir_rd_q <= sh_n[0];
                            tx_low_q <= 1'b1;
                        end else begin
                            st_q <= dmsp_pkg::DMSP_IDLE;
                        end
                    end
                end
                dmsp_pkg::DMSP_ADDR_ACK: begin
                    cnt_q <= `DMSP_FIRST_BIT;
                    if (dir_rd_q) begin
                        // first read bit goes out on the falling edge
                        st_q <= dmsp_pkg::DMSP_READ;
                        tx_low_q <= !rd_byte[7];
                        sh_q <= {rd_byte[6:0], 1'b0};
                    end else begin
                        st_q <= dmsp_pkg::DMSP_SUB;
                        tx_low_q <= 1'b0;
                        hold_q <= 1'b0;
                    end
                end
                dmsp_pkg::DMSP_SUB: begin
                    cnt_q <= cnt_q + 3'h1;
                    sh_q <= sh_n;
                    if (cnt_q == `DMSP_FIRST_BIT) begin
                        hold_q <= sda;
                    end
                    if (cnt_q == `DMSP_LAST_BIT) begin
                        byte_q <= 2'h0;
                        sub_q <= sh_n[3:0];
                        rd_sel_q <= sh_n[0];
                        if (sh_n <= `DMSP_WR_MAX) begin
                            rd_mode_q <= 1'b0;
                            st_q <= mode3w ? dmsp_pkg::DMSP_DATA : dmsp_pkg::DMSP_SUB_ACK;
                            tx_low_q <= !mode3w;
                        end else if (sh_n == `DMSP_RD_STATUS || sh_n == `DMSP_RD_ADC) begin
                            rd_mode_q <= 1'b1;
                            if (mode3w) begin
                                // no address phase: data follows at once
                                st_q <= dmsp_pkg::DMSP_READ;
                                tx_low_q <= !snap_q[sh_n[0]][7];
                                sh_q <= {snap_q[sh_n[0]][6:0], 1'b0};
                            end else begin
                                st_q <= dmsp_pkg::DMSP_SUB_ACK;
                                tx_low_q <= 1'b1;
                            end
                        end else begin
                            // unknown subaddress is left unacknowledged
                            st_q <= dmsp_pkg::DMSP_IDLE;
                            hold_q <= 1'b0;
                        end
                    end
                end
                dmsp_pkg::DMSP_SUB_ACK: begin
                    cnt_q <= `DMSP_FIRST_BIT;
                    tx_low_q <= 1'b0;
                    // a read drops to idle to wait for the repeated start
                    st_q <= rd_mode_q ? dmsp_pkg::DMSP_IDLE : dmsp_pkg::DMSP_DATA;
                end
                dmsp_pkg::DMSP_DATA: begin
                    cnt_q <= cnt_q + 3'h1;
                    sh_q <= sh_n;
                    if (cnt_q == `DMSP_LAST_BIT) begin
                        st_q <= mode3w ? dmsp_pkg::DMSP_DATA : dmsp_pkg::DMSP_DATA_ACK;
                        tx_low_q <= !mode3w;
                        if (byte_q == 2'h0 && !dmsp_is_byte_reg(sub_q)) begin
                            hi_q <= sh_n;
                            byte_q <= 2'h1;
                        end else if (byte_q != 2'h2) begin
                            // register handed over only once complete
                            wr_q.addr <= sub_q;
                            wr_q.data <= (byte_q == 2'h1) ? {hi_q, sh_n} : {8'h00, sh_n};
                            wr_tgl_q <= !wr_tgl_q;
                            byte_q <= 2'h2;
                        end
                    end
                end
                dmsp_pkg::DMSP_DATA_ACK: begin
                    cnt_q <= `DMSP_FIRST_BIT;
                    tx_low_q <= 1'b0;
                    st_q <= dmsp_pkg::DMSP_DATA;
                end
                dmsp_pkg::DMSP_READ: begin
                    cnt_q <= cnt_q + 3'h1;
                    sh_q <= {sh_q[6:0], 1'b0};
                    if (cnt_q == `DMSP_LAST_BIT) begin
                        // release for the master's acknowledge slot
                        tx_low_q <= 1'b0;
                        st_q <= mode3w ? dmsp_pkg::DMSP_IDLE : dmsp_pkg::DMSP_READ_ACK;
                        hold_q <= 1'b0;
                    end else begin
                        tx_low_q <= !sh_q[7];
                    end
                end
                dmsp_pkg::DMSP_READ_ACK: begin
                    st_q <= dmsp_pkg::DMSP_IDLE;
                    tx_low_q <= 1'b0;
                end
                default: begin
                    st_q <= dmsp_pkg::DMSP_IDLE;
                    tx_low_q <= 1'b0;
                end
            endcase
        end
    end

    // data line changes only while the clock is low
    always_ff @(negedge i_serial_clock_line or posedge i_rst) begin
        if (i_rst) begin
            o_serial_data_line_oen <= 1'b1;
        end else begin
            o_serial_data_line_oen <= !tx_low_q;
        end
    end

    // ------------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------------
    localparam int SYNC_W = 20;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic pd_s;
    logic rx_s;
    logic hold_s;
    logic wr_s;
    logic [7:0] adc_s;
    logic [7:0] rssi_s;
    logic wr_seen_q;
    logic wr_evt;
    logic [15:0] regs_q [`DMSP_NREGS];
    logic rx_prev_q;
    logic rx_rise;
    logic [RATE_W-1:0] rate_cnt_q;
    logic rate_ok_q;
    logic rssi_ok_q;
    dmsp_pkg::dmsp_mode_type mode_q;

    // pins and the link's write toggle and hold flops pass two flip-flops before use; the write word wr_q is used directly
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (i_clk_en) begin
            sync1_q <= {i_rssi_level, i_adc_value, wr_tgl_q, hold_q,
                        i_powerdown_detect_line, i_rx_data};
            sync2_q <= sync1_q;
        end
    end

    assign rx_s = sync2_q[0];
    assign pd_s = sync2_q[1];
    assign hold_s = sync2_q[2];
    assign wr_s = sync2_q[3];
    assign adc_s = sync2_q[11:4];
    assign rssi_s = sync2_q[19:12];
    assign wr_evt = i_clk_en && (wr_s != wr_seen_q);

    // write register file; the word is stable long before its toggle lands
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            wr_seen_q <= 1'b0;
            for (int i = 0; i < `DMSP_NREGS; i++) begin
                regs_q[i] <= 16'h0000;
            end
            regs_q[`DMSP_SUB_CONFIG] <= `DMSP_CONFIG_RST;
        end else if (i_clk_en) begin
            wr_seen_q <= wr_s;
            if (wr_evt) begin
                regs_q[wr_q.addr] <= wr_q.data;
            end
        end
    end

    // read snapshot frozen while the link shifts it out
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            snap_q[0] <= 8'h00;
            snap_q[1] <= 8'h00;
        end else if (i_clk_en && !hold_s) begin
            snap_q[0] <= {6'h00, rssi_ok_q, rate_ok_q};
            snap_q[1] <= adc_s;
        end
    end

    // data-valid detector: period between rising data edges in clocks
    assign rx_rise = rx_s && !rx_prev_q;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rx_prev_q <= 1'b0;
            rate_cnt_q <= '0;
            rate_ok_q <= 1'b0;
            rssi_ok_q <= 1'b0;
        end else if (i_clk_en) begin
            rx_prev_q <= rx_s;
            if (rx_rise) begin
                rate_ok_q <= dmsp_in_window(16'(rate_cnt_q),
                    regs_q[`DMSP_SUB_COUNT_LO], regs_q[`DMSP_SUB_COUNT_HI]);
                rate_cnt_q <= '0;
            end else if (rate_cnt_q != '1) begin
                // saturate so a stuck line never wraps into the window
                rate_cnt_q <= rate_cnt_q + 1'b1;
            end
            rssi_ok_q <= rssi_s >= regs_q[`DMSP_SUB_RSSI][7:0];
        end
    end

    // wake-up mode selection
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            mode_q <= dmsp_pkg::DMSP_SLAVE;
        end else if (i_clk_en) begin
            if (regs_q[`DMSP_SUB_CONFIG][`DMSP_BIT_SELF_POLL]) begin
                mode_q <= dmsp_pkg::DMSP_SELF_POLL;
            end else if (regs_q[`DMSP_SUB_CONFIG][`DMSP_BIT_TIMER]) begin
                mode_q <= dmsp_pkg::DMSP_TIMER;
            end else begin
                mode_q <= dmsp_pkg::DMSP_SLAVE;
            end
        end
    end

    // power state and the shared detect line
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_powerdown_detect_line_oen <= 1'b1;
            o_powerdown <= 1'b0;
            o_op_mode <= dmsp_pkg::DMSP_SLAVE;
            o_config <= `DMSP_CONFIG_RST;
        end else if (i_clk_en) begin
            o_powerdown_detect_line_oen <= !(mode_q == dmsp_pkg::DMSP_SELF_POLL &&
                rate_ok_q && rssi_ok_q);
            // an outside low on the line keeps the device on unless the global powerdown bit is set
            o_powerdown <= pd_s || regs_q[`DMSP_SUB_CONFIG][`DMSP_BIT_GLOBAL_PD];
            o_op_mode <= mode_q;
            o_config <= regs_q[`DMSP_SUB_CONFIG];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_pd_cause;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en ##1 i_clk_en |-> o_powerdown ==
            ($past(pd_s) || $past(regs_q[`DMSP_SUB_CONFIG][`DMSP_BIT_GLOBAL_PD]));
    endproperty
    a_pd_cause: assert property (p_pd_cause) else $error("powerdown mismatch");

    property p_detect_drive;
        @(posedge i_clock) disable iff (i_rst)
        $fell(o_powerdown_detect_line_oen) |->
            $past(mode_q == dmsp_pkg::DMSP_SELF_POLL && rate_ok_q && rssi_ok_q);
    endproperty
    a_detect_drive: assert property (p_detect_drive) else $error("bad detect drive");

    property p_mode_sel;
        @(posedge i_clock) disable iff (i_rst)
        i_clk_en && regs_q[`DMSP_SUB_CONFIG][`DMSP_BIT_SELF_POLL] ##1 i_clk_en
            |=> o_op_mode == dmsp_pkg::DMSP_SELF_POLL;
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("mode not self polling");

    property p_cfg_hold;
        @(posedge i_clock) disable iff (i_rst)
        !wr_evt |=> $stable(regs_q[`DMSP_SUB_CONFIG]);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write");

    property p_rate_hold;
        @(posedge i_clock) disable iff (i_rst)
        !rx_rise |=> $stable(rate_ok_q);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate flag moved");

    property p_addr_match;
        @(posedge i_serial_clock_line) disable iff (i_rst)
        st_q == dmsp_pkg::DMSP_ADDR_ACK |-> sh_q[7:1] == `DMSP_DEV_ADDR && tx_low_q;
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("acked wrong address");

    property p_sel_idle;
        @(posedge i_serial_clock_line) disable iff (i_rst)
        mode3w && i_select_line_n && !frame_start |=> st_q == dmsp_pkg::DMSP_IDLE;
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("active with select high");

    // a cut frame never hands a word across to the system side
    property p_abort_hold;
        @(posedge i_serial_clock_line) disable iff (i_rst)
        !frame_start && (stop_pend || (mode3w && i_select_line_n)) |=> $stable(wr_tgl_q);
    endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("write after abort");

    property p_data_ack;
        @(posedge i_serial_clock_line) disable iff (i_rst)
        st_q == dmsp_pkg::DMSP_DATA && cnt_q == `DMSP_LAST_BIT && !mode3w &&
            !frame_start && !stop_pend |=> st_q == dmsp_pkg::DMSP_DATA_ACK && tx_low_q;
    endproperty
    a_data_ack: assert property (p_data_ack) else $error("missing data ack");

    property p_read_dir;
        @(posedge i_serial_clock_line) disable iff (i_rst)
        st_q == dmsp_pkg::DMSP_ADDR_ACK && dir_rd_q && !frame_start && !stop_pend
            |=> st_q == dmsp_pkg::DMSP_READ;
    endproperty
    a_read_dir: assert property (p_read_dir) else $error("read not started");

    c_write: cover property (@(posedge i_clock) disable iff (i_rst) wr_evt);
    c_read: cover property (@(posedge i_serial_clock_line) disable iff (i_rst)
        st_q == dmsp_pkg::DMSP_READ_ACK);
    c_detect: cover property (@(posedge i_clock) disable iff (i_rst)
        $fell(o_powerdown_detect_line_oen));

endmodule

// ===== pkg/dmsp_defines.svh
`ifndef DMSP_DEFINES_SVH
`define DMSP_DEFINES_SVH

// seven-bit device address on the two-wire bus
`define DMSP_DEV_ADDR 7'h70
// highest write subaddress and the two read subaddresses
`define DMSP_WR_MAX 8'h0F
`define DMSP_RD_STATUS 8'h80
`define DMSP_RD_ADC 8'h81
// bit counter value of the last bit of a byte
`define DMSP_LAST_BIT 3'h7
`define DMSP_FIRST_BIT 3'h0
// write register indices the block itself reads or sizes
`define DMSP_SUB_CONFIG 4'h0
`define DMSP_SUB_LPF 4'h3
`define DMSP_SUB_COUNT_LO 4'h6
`define DMSP_SUB_COUNT_HI 4'h7
`define DMSP_SUB_RSSI 4'h8
`define DMSP_SUB_CLK_DIV 4'hD
`define DMSP_SUB_XTAL_CFG 4'hE
// configuration reset value and its control bits
`define DMSP_CONFIG_RST 16'h04F9
`define DMSP_BIT_GLOBAL_PD 14
`define DMSP_BIT_SELF_POLL 1
`define DMSP_BIT_TIMER 2
// number of write registers
`define DMSP_NREGS 16

`endif

// ===== pkg/dmsp_pkg.sv
package dmsp_pkg;

    // operating modes chosen by the wake-up logic
    typedef enum logic [1:0] {
        DMSP_SLAVE,
        DMSP_SELF_POLL,
        DMSP_TIMER
    } dmsp_mode_type;

    // states of the serial link engine
    typedef enum logic [3:0] {
        DMSP_IDLE,
        DMSP_ADDR,
        DMSP_ADDR_ACK,
        DMSP_SUB,
        DMSP_SUB_ACK,
        DMSP_DATA,
        DMSP_DATA_ACK,
        DMSP_READ,
        DMSP_READ_ACK
    } dmsp_link_type;

    // one complete register write handed to the system domain
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] data;
    } dmsp_wr_type;

endpackage

// ===== test/dmsp_host.sv
`timescale 1ns/1ps
// bus master stand-in: its clock moves only inside its tasks and idles high between them
module dmsp_host (
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oen,
    output logic o_sel_n
);
    // idle: clock high, data released to the pull-up, select inactive
    initial begin
        o_scl = 1'b1;
        o_sda_oen = 1'b1;
        o_sel_n = 1'b1;
    end
    // one clock: data set mid-low, line sampled mid-high so the device output has settled
    task automatic clk_bit(input logic b, output logic s);
        o_scl = 1'b0;
        #16 o_sda_oen = b;
        #16 o_scl = 1'b1;
        #16 s = i_sda;
        #16;
    endtask
    // byte msb first; two-wire adds a released ninth clock that samples the ack
    task automatic xfer(input logic [7:0] d, input logic tw, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], r[i]);
        a = 1'b1;
        if (!tw) clk_bit(1'b1, a);
    endtask
    // data edge while clock high: 1 then 0 is a start, 0 then 1 a stop
    task automatic cond(input logic first, input logic last);
        o_scl = 1'b0;
        #16 o_sda_oen = first;
        #16 o_scl = 1'b1;
        #16 o_sda_oen = last;
        #16;
    endtask
    // three-wire frame edge; the data line is released so it never rests low
    task automatic sel(input logic on);
        o_sda_oen = 1'b1;
        #16 o_sel_n = !on;
        #16;
    endtask
endmodule

// ===== test/dmsp_port_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dmsp_port_tb;
    logic i_clock, i_rst, i_rx_data, pin, ext_oen, dut_oen, det_oen, scl, host_oen, sel_n, a, pd;
    logic [7:0] rssi, adc, r;
    logic ce;
    logic [15:0] cfg;
    dmsp_pkg::dmsp_mode_type mode;
    int error_cnt, checks, cyc;
    // both lines are open drain with a pull-up: low if any party pulls
    wire logic sda = host_oen & dut_oen;
    wire logic det = ext_oen & det_oen;
    dmsp_port u_dmsp_port (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(ce),
        .i_protocol_select_pin(pin), .i_serial_clock_line(scl), .i_serial_data_line(sda),
        .o_serial_data_line_oen(dut_oen), .i_select_line_n(sel_n),
        .i_powerdown_detect_line(det), .o_powerdown_detect_line_oen(det_oen),
        .i_rx_data(i_rx_data), .i_rssi_level(rssi), .i_adc_value(adc),
        .o_powerdown(pd), .o_op_mode(mode), .o_config(cfg));
    dmsp_host u_dmsp_host (.i_sda(sda), .o_scl(scl), .o_sda_oen(host_oen), .o_sel_n(sel_n));
    // 125 MHz system clock
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    // sliced data with a 40-cycle period, inside the rate window written below
    always begin
        repeat (20) @(negedge i_clock);
        i_rx_data = ~i_rx_data;
    end
    // hang guard: the sequence needs well under 10000 cycles
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // frame opening: two-wire sends start and write address, three-wire lowers select
    task automatic open_frame(input logic [7:0] sub);
        if (pin) u_dmsp_host.sel(1'b1);
        else u_dmsp_host.cond(1'b1, 1'b0);
        if (!pin) u_dmsp_host.xfer(8'hE0, 1'b0, r, a);
        u_dmsp_host.xfer(sub, pin, r, a);
        `CHK(a, pin)
    endtask
    // frame close, then room for the write to cross into the system domain
    task automatic close_frame();
        if (pin) u_dmsp_host.sel(1'b0);
        else u_dmsp_host.cond(1'b0, 1'b1);
        repeat (12) @(negedge i_clock);
    endtask
    task automatic wr(input logic [7:0] sub, input logic [15:0] d, input int n);
        open_frame(sub);
        if (n > 1) u_dmsp_host.xfer(d[15:8], pin, r, a);
        u_dmsp_host.xfer(d[7:0], pin, r, a);
        `CHK(a, pin)
        close_frame();
    endtask
    task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
        open_frame(sub);
        if (!pin) u_dmsp_host.cond(1'b1, 1'b0);
        if (!pin) u_dmsp_host.xfer(8'hE1, 1'b0, r, a);
        u_dmsp_host.xfer(8'hFF, pin, r, a);
        `CHK(r, exp)
        close_frame();
    endtask
    // main sequence; the outside party holds the detect line low to keep the device on
    initial begin
        i_rst = 1'b0;
        ce = 1'b1;
        pin = 1'b0;
        ext_oen = 1'b0;
        i_rx_data = 1'b0;
        rssi = 8'h80;
        adc = 8'hA5;
        // raise reset after time zero so the link's asynchronous clear sees a real edge
        #1 i_rst = 1'b1;
        repeat (5) @(negedge i_clock);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clock);
        `CHK(cfg, 16'h04F9)
        `CHK(mode, dmsp_pkg::DMSP_SLAVE)
        wr(8'h00, 16'h0002, 2);
        `CHK(cfg, 16'h0002)
        `CHK(mode, dmsp_pkg::DMSP_SELF_POLL)
        wr(8'h00, 16'h00FF, 1);
        `CHK(cfg, 16'h0002)
        u_dmsp_host.cond(1'b1, 1'b0);
        u_dmsp_host.xfer(8'hE2, 1'b0, r, a);
        `CHK(a, 1'b1)
        u_dmsp_host.cond(1'b0, 1'b1);
        // a subaddress outside both ranges is left unacknowledged
        u_dmsp_host.cond(1'b1, 1'b0);
        u_dmsp_host.xfer(8'hE0, 1'b0, r, a);
        u_dmsp_host.xfer(8'h90, 1'b0, r, a);
        `CHK(a, 1'b1)
        u_dmsp_host.cond(1'b0, 1'b1);
        wr(8'h06, 16'h0010, 2);
        wr(8'h07, 16'h0100, 2);
        wr(8'h08, 16'h0040, 1);
        repeat (100) @(negedge i_clock);
        `CHK(det_oen, 1'b0)
        rd(8'h80, 8'h03);
        rd(8'h81, 8'hA5);
        pin = 1'b1;
        adc = 8'h5A;
        rd(8'h81, 8'h5A);
        wr(8'h00, 16'h0004, 2);
        `CHK(mode, dmsp_pkg::DMSP_TIMER)
        // bytes clocked while deselected must not land
        repeat (3) u_dmsp_host.xfer(8'h00, 1'b1, r, a);
        repeat (12) @(negedge i_clock);
        `CHK(cfg, 16'h0004)
        wr(8'h00, 16'h4000, 2);
        `CHK(pd, 1'b1)
        wr(8'h00, 16'h0000, 2);
        `CHK(pd, 1'b0)
        ext_oen = 1'b1;
        repeat (8) @(negedge i_clock);
        `CHK(pd, 1'b1)
        // with the enable low the system side must hold its state
        ce = 1'b0;
        ext_oen = 1'b0;
        repeat (8) @(negedge i_clock);
        `CHK(pd, 1'b1)
        ce = 1'b1;
        repeat (8) @(negedge i_clock);
        `CHK(pd, 1'b0)
        wrap_up();
    end
endmodule
